// >>> logic/annp_pkg.sv
// Constants for the next-page register bank: offsets, bit positions, reset values.
// Assumes a 5-bit management register address and 16-bit register data.
`default_nettype none

package annp_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_EXPANSION  = 5'h06;
  localparam logic [ADDR_W-1:0] OFF_NP_TX      = 5'h07;
  localparam logic [ADDR_W-1:0] OFF_PARTNER_NP = 5'h08;

  // Reset values
  localparam logic [DATA_W-1:0] RST_EXPANSION  = 16'h0004;
  localparam logic [DATA_W-1:0] RST_NP_TX      = 16'h2001;
  localparam logic [DATA_W-1:0] RST_PARTNER_NP = 16'h0000;

  // Expansion bit positions
  localparam int unsigned EXP_PARTNER_AN = 0;
  localparam int unsigned EXP_PAGE_RX    = 1;
  localparam int unsigned EXP_LOCAL_NP   = 2;
  localparam int unsigned EXP_PARTNER_NP = 3;
  localparam int unsigned EXP_PD_FAULT   = 4;

  // Next-page word bit positions, shared by transmit and partner words
  localparam int unsigned NP_MORE    = 15;
  localparam int unsigned NP_RSVD    = 14;
  localparam int unsigned NP_MSG     = 13;
  localparam int unsigned NP_ACK2    = 12;
  localparam int unsigned NP_TOGGLE  = 11;
  localparam int unsigned NP_CODE_HI = 10;

  // Bits software may write in the transmit word: 15, 13, 12, 10..0
  localparam logic [DATA_W-1:0] NP_TX_WR_MASK = 16'hb7ff;
  // Bits captured from the partner word: all but reserved 14
  localparam logic [DATA_W-1:0] NP_RX_MASK    = 16'hbfff;
endpackage : annp_pkg

`default_nettype wire

// >>> logic/annp_latching_high_flag.sv
// Latching-high status flag: set by an event, cleared by a read request.
// Assumes event and clear come from logic on the same clock.
`default_nettype none

module annp_latching_high_flag (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control
  input  wire logic set_in,
  input  wire logic clear_in,
  // State
  output logic      flag_q
);
  logic flag_d;

  // Set wins over clear, so an event in the clearing cycle is kept
  assign flag_d = set_in | (flag_q & ~clear_in);

  always_ff @(posedge clock)
  begin
    if (rst)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end
endmodule : annp_latching_high_flag

`default_nettype wire

// >>> logic/annp_regs.sv
// Expansion, next-page transmit and partner next-page registers.
// Assumes a management engine on the same clock issuing one-cycle read/write
// strobes, and an arbitration machine on the same clock driving the line side.
`default_nettype none

// Behaviour
// RL1: Expansion bit 2 always reads 1: local next-page support, read-only.
// RL2: Expansion bit 3 follows partner base-page next-page ability; resets 0.
// RL3: Expansion bits 1 and 4 latch high on page received and detect fault.
// RL4: Expansion bit 0 shows partner auto-negotiation ability; bits 15..5 read 0.
// RL5: Transmit word bit 15 resets 0, bit 13 resets 1, code 10..0 resets 1.
// RL6: Transmit bit 12 writable, resets 0; bit 14 reads 0.
// RL7: Transmit bit 11 is inverse of previous exchanged toggle; read-only, resets 0.
// RL8: Received next page captured: bits 15, 13, 12 read-only, reset 0.
// RL9: Partner toggle in bit 11, code in bits 10..0, reset 0.
// RL10: Reading expansion clears latched flags unless the condition persists.
module annp_regs #(
  parameter int unsigned ADDR_W = annp_pkg::ADDR_W,
  parameter int unsigned DATA_W = annp_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Management register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  // Arbitration side
  input  wire logic              an_partner_an_able,
  input  wire logic              an_partner_np_able,
  input  wire logic              an_pd_fault,
  input  wire logic              an_page_rx,
  input  wire logic [DATA_W-1:0] an_rx_word,
  input  wire logic              an_word_sent,
  input  wire logic              an_sent_toggle,
  output logic      [DATA_W-1:0] np_tx_word
);
  // The field layout is fixed by the package, so other widths cannot be served
  if (ADDR_W != annp_pkg::ADDR_W || DATA_W != annp_pkg::DATA_W)
  begin : g_bad_width
    $error("annp_regs: address must be 5 bits and data 16 bits");
  end

  logic [DATA_W-1:0] tx_q;
  logic [DATA_W-1:0] tx_d;
  logic              toggle_q;
  logic              toggle_d;
  logic [DATA_W-1:0] lp_q;
  logic [DATA_W-1:0] lp_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              page_rx_flag;
  logic              pd_flag;

  // Address match, shared by every register select
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    return addr == offset;
  endfunction : reg_hit

  // Decode
  wire sel_exp = reg_hit(reg_addr, annp_pkg::OFF_EXPANSION);
  wire sel_tx  = reg_hit(reg_addr, annp_pkg::OFF_NP_TX);
  wire sel_lp  = reg_hit(reg_addr, annp_pkg::OFF_PARTNER_NP);
  wire wr_tx   = reg_wr & sel_tx;
  wire rd_exp  = reg_rd & sel_exp;

  // Latched flags; the live event overrides the read clear
  annp_latching_high_flag u_page_rx (
    .clock    (clock),
    .rst      (rst),
    .set_in   (an_page_rx),  // RL3
    .clear_in (rd_exp),      // RL10
    .flag_q   (page_rx_flag)
  );

  annp_latching_high_flag u_pd_fault (
    .clock    (clock),
    .rst      (rst),
    .set_in   (an_pd_fault), // RL3
    .clear_in (rd_exp),      // RL10
    .flag_q   (pd_flag)
  );

  // Expansion view: reserved bits 15..5 are zero
  wire [DATA_W-1:0] exp_view = {11'h000,
                                pd_flag,                          // RL3
                                an_partner_np_able,               // RL2
                                1'b1,                             // RL1
                                page_rx_flag,                     // RL3
                                an_partner_an_able};              // RL4

  // Transmit word: only writable bits change, toggle kept separately
  assign tx_d = wr_tx ? (reg_wdata & annp_pkg::NP_TX_WR_MASK)
                      : tx_q;                                     // RL5 RL6
  // Toggle kept apart from tx_q so a software write can never disturb it
  assign toggle_d = an_word_sent ? ~an_sent_toggle : toggle_q;    // RL7
  wire [DATA_W-1:0] tx_view = tx_q | ({{(DATA_W-1){1'b0}}, toggle_q} << annp_pkg::NP_TOGGLE);

  // Partner word: reserved bit 14 forced to zero
  assign lp_d = an_page_rx ? (an_rx_word & annp_pkg::NP_RX_MASK) : lp_q; // RL8 RL9

  // Read mux; unmapped offsets read zero
  // A read that meets a write returns the word from before the write
  assign rdata_d = !reg_rd ? rdata_q :
                   sel_exp ? exp_view :
                   sel_tx  ? tx_view :
                   sel_lp  ? lp_q :
                             {DATA_W{1'b0}};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tx_q     <= annp_pkg::RST_NP_TX;                            // RL5
      toggle_q <= 1'b0;
      lp_q     <= annp_pkg::RST_PARTNER_NP;
      rdata_q  <= {DATA_W{1'b0}};
    end
    else
    begin
      tx_q     <= tx_d;
      toggle_q <= toggle_d;
      lp_q     <= lp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata  = rdata_q;
  // The arbiter always sees the current word, toggle included
  assign np_tx_word = tx_view;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Flags are watched at the latch itself, since each expansion read may clear them
  a_local_np_one: assert property ( // RL1
    rd_exp |=> reg_rdata[annp_pkg::EXP_LOCAL_NP] == 1'b1)
    else $error("expansion local next-page bit not one");

  a_partner_np_bit: assert property ( // RL2
    rd_exp |=> reg_rdata[annp_pkg::EXP_PARTNER_NP] == $past(an_partner_np_able))
    else $error("expansion partner next-page bit wrong");

  a_page_rx_latch: assert property ( // RL3
    an_page_rx |=> page_rx_flag)
    else $error("page received flag not latched");

  a_page_rx_hold: assert property ( // RL3
    (page_rx_flag && !rd_exp) |=> page_rx_flag)
    else $error("page received flag dropped without a read");

  a_pd_fault_latch: assert property ( // RL3
    an_pd_fault |=> pd_flag)
    else $error("parallel detect fault flag not latched");

  a_pd_fault_hold: assert property ( // RL3
    (pd_flag && !rd_exp) |=> pd_flag)
    else $error("parallel detect fault flag dropped without a read");

  a_exp_upper_zero: assert property ( // RL4
    rd_exp |=> reg_rdata[15:5] == 11'h000 &&
               reg_rdata[annp_pkg::EXP_PARTNER_AN] == $past(an_partner_an_able))
    else $error("expansion upper bits or partner ability wrong");

  a_tx_write_fields: assert property ( // RL5
    wr_tx |=> np_tx_word[15] == $past(reg_wdata[15]) &&
              np_tx_word[13] == $past(reg_wdata[13]) &&
              np_tx_word[10:0] == $past(reg_wdata[10:0]))
    else $error("transmit word fields not written");

  a_tx_hold: assert property ( // RL5
    !wr_tx |=> (np_tx_word & annp_pkg::NP_TX_WR_MASK) ==
               ($past(np_tx_word) & annp_pkg::NP_TX_WR_MASK))
    else $error("transmit word changed without a write");

  a_tx_ack2_rsvd: assert property ( // RL6
    wr_tx |=> np_tx_word[annp_pkg::NP_ACK2] == $past(reg_wdata[12]) &&
              np_tx_word[annp_pkg::NP_RSVD] == 1'b0)
    else $error("acknowledge-2 or reserved transmit bit wrong");

  a_tx_toggle_inv: assert property ( // RL7
    an_word_sent |=> np_tx_word[annp_pkg::NP_TOGGLE] == !$past(an_sent_toggle))
    else $error("transmit toggle not inverse of sent toggle");

  a_toggle_ro: assert property ( // RL7
    (wr_tx && !an_word_sent) |=> $stable(np_tx_word[annp_pkg::NP_TOGGLE]))
    else $error("software changed the transmit toggle");

  a_lp_capture: assert property ( // RL8
    an_page_rx |=> lp_q[15:12] == ($past(an_rx_word[15:12]) & 4'hb))
    else $error("partner next page header not captured");

  a_lp_stands: assert property ( // RL8
    !an_page_rx |=> $stable(lp_q))
    else $error("partner next page changed without a received page");

  a_lp_toggle_code: assert property ( // RL9
    an_page_rx |=> lp_q[11:0] == $past(an_rx_word[11:0]))
    else $error("partner toggle or code not captured");

  a_read_clear: assert property ( // RL10
    (rd_exp && !an_page_rx && !an_pd_fault) |=> !page_rx_flag && !pd_flag)
    else $error("latched flags not cleared by read");

  a_clear_collide: assert property ( // RL10
    (rd_exp && an_page_rx) |=> page_rx_flag)
    else $error("page received event lost under a read clear");

  a_pd_collide: assert property ( // RL10
    (rd_exp && an_pd_fault) |=> pd_flag)
    else $error("parallel detect event lost under a read clear");

  c_rx_then_read: cover property (an_page_rx ##[1:8] rd_exp);
  c_clear_collide: cover property (rd_exp && an_page_rx && page_rx_flag);
  c_tx_write_sent: cover property (wr_tx ##[1:4] an_word_sent);
  c_fault_read: cover property (an_pd_fault ##1 rd_exp);
  c_np_able_read: cover property (rd_exp && an_partner_np_able && an_partner_an_able);
endmodule : annp_regs

`default_nettype wire

// >>> bench/annp_arb_model.sv
// Arbitration-side model: partner levels and one-cycle line events.
// Assumes one bench process calls its tasks, all on the register clock.
`default_nettype none
module annp_arb_model (
  // Clock
  input  wire logic                         clock,
  // Line side
  output logic                              an_able,
  output logic                              np_able,
  output logic                              pd_fault,
  output logic                              page_rx,
  output logic [annp_pkg::DATA_W-1:0]       rx_word,
  output logic                              word_sent,
  output logic                              sent_tog
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {an_able, np_able, pd_fault, page_rx, rx_word, word_sent, sent_tog} = '0;
  // Word is inverted once its strobe drops, so stale data is never mistaken for valid
  task automatic page(input logic [annp_pkg::DATA_W-1:0] w);
    @(posedge clock);
    page_rx <= 1'b1;
    rx_word <= w;
    @(posedge clock);
    page_rx <= 1'b0;
    rx_word <= ~w;
  endtask : page
  task automatic sent(input logic t);
    @(posedge clock);
    word_sent <= 1'b1;
    sent_tog  <= t;
    @(posedge clock);
    word_sent <= 1'b0;
    sent_tog  <= ~t;
  endtask : sent
  task automatic fault();
    @(posedge clock);
    pd_fault <= 1'b1;
    @(posedge clock);
    pd_fault <= 1'b0;
  endtask : fault
  task automatic ability(input logic a, input logic n);
    @(posedge clock);
    an_able <= a;
    np_able <= n;
  endtask : ability
endmodule : annp_arb_model
`default_nettype wire

// >>> bench/tb_annp_regs.sv
// Self-checking bench for the next-page register bank.
// Assumes one-cycle read latency and the model above on the line side.
`default_nettype none
module tb_annp_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic [4:0]  reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, np_tx_word, rx_word, d, w;
  logic        an_able, np_able, pd_fault, page_rx, word_sent, sent_tog;
  logic [15:0] exp_q[$];
  int          fail_count = 0, total_checks = 0, seed = 7;
  always #2.5 clock = ~clock;
  annp_arb_model m (.clock(clock), .an_able(an_able), .np_able(np_able), .pd_fault(pd_fault),
    .page_rx(page_rx), .rx_word(rx_word), .word_sent(word_sent), .sent_tog(sent_tog));
  annp_regs uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .an_partner_an_able(an_able), .an_partner_np_able(np_able), .an_pd_fault(pd_fault),
    .an_page_rx(page_rx), .an_rx_word(rx_word), .an_word_sent(word_sent),
    .an_sent_toggle(sent_tog), .np_tx_word(np_tx_word));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr
  // Read data lands one edge after the read is taken
  always @(posedge clock)
  begin
    if (rd_seen && exp_q.size() > 0)
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(5'h06, 16'h0004);
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h0000);
    rd(5'h1f, 16'h0000);
    check("np_tx_word", np_tx_word, 16'h2001);
    $display("test reset done");
    d = 16'($random(seed));
    wr(5'h06, 16'hffff);
    wr(5'h07, d);
    rd(5'h06, 16'h0004);
    rd(5'h07, d & annp_pkg::NP_TX_WR_MASK);
    m.sent(1'b0);
    rd(5'h07, (d & annp_pkg::NP_TX_WR_MASK) | 16'h0800);
    check("np_tx_word", np_tx_word, (d & annp_pkg::NP_TX_WR_MASK) | 16'h0800);
    $display("test transmit word done");
    w = 16'($random(seed));
    m.page(w);
    rd(5'h08, w & 16'hbfff);
    rd(5'h06, 16'h0006);
    rd(5'h06, 16'h0004);
    m.fault();
    rd(5'h06, 16'h0014);
    rd(5'h06, 16'h0004);
    m.ability(1'b1, 1'b1);
    rd(5'h06, 16'h000d);
    $display("test flags done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h0000);
    check("np_tx_word", np_tx_word, 16'h2001);
    $display("test mid-run reset done");
    for (int i = 0; i < 10 && exp_q.size() > 0; i++)
      @(posedge clock);
    if (exp_q.size() > 0)
      fail_count++;
    final_report();
  end
endmodule : tb_annp_regs
`default_nettype wire
